// [core/qcr_readout.sv]
`timescale 1ns/1ns
// Contract
// - Each counter overflow or underflow gives one half-cycle cascade count pulse.
// - The cascade pulse appears in the same cycle the counter takes its wrapped value.
// - Direction is valid one cycle after the pulse and one cycle before it, except for a wrap one cycle after a wrap, which keeps the old direction.
// - Cascade pulse and direction ignore the inhibit and keep running during reads.
// - Falling edge with enable low, selects low/high sets inhibit; bus shows top byte.
// - Selects high/high, low/low, high/low give bytes two, three, four; inhibit stays.
// - Output enable high at a falling edge clears the inhibit, selects ignored.
// - While output enable is high the eight data lines are not driven.
// - First rising edge after inhibit clears reloads the latch from the counter.
// - While inhibited the latch holds, even if the counter changes or wraps.
// - The latch captures the counter on every rising edge unless inhibited.
// - Reset clears the inhibit asynchronously and clears the latch to zero.
module qcr_readout (
  input wire logic clk_sys, // System clock, 100 MHz.
  input wire logic rst, // Asynchronous reset, active high.
  input wire logic [qcr_pkg::AV_ADDR_W-1:0] avs_address, // Avalon byte address.
  input wire logic avs_read, // Avalon read request.
  input wire logic avs_write, // Avalon write request.
  input wire logic [qcr_pkg::AV_DATA_W-1:0] avs_writedata, // Avalon write data.
  input wire logic [qcr_pkg::AV_BE_W-1:0] avs_byteenable, // Avalon byte enables.
  output logic [qcr_pkg::AV_DATA_W-1:0] avs_readdata, // Avalon read data.
  output logic avs_waitrequest, // Avalon wait request.
  input wire logic dec_count_strobe, // One count from the decoder, same clock.
  input wire logic dec_count_up, // Decoder direction, 1 = up.
  input wire logic byte_select_a, // Byte select pin a.
  input wire logic byte_select_b, // Byte select pin b.
  input wire logic out_enable_n, // Bus output enable pin, active low.
  output logic [qcr_pkg::BYTE_W-1:0] data_out, // Data bus output value.
  output logic data_oe, // Data bus drive enable.
  output logic cascade_count_pulse, // Cascade count pulse.
  output logic cascade_dir_up // Cascade direction, 1 = up.
);
  import qcr_pkg::*;

  // Returns one when a step in the given direction from this value wraps the counter.
  function automatic logic qcr_wraps(input logic [CNT_W-1:0] value, input logic up);
    qcr_wraps = up ? (value == CNT_ONES) : (value == CNT_ZERO);
  endfunction

  // Returns the counter value after one step in the given direction.
  function automatic logic [CNT_W-1:0] qcr_step(input logic [CNT_W-1:0] value, input logic up);
    qcr_step = up ? value + CNT_ONE : value - CNT_ONE;
  endfunction

  logic sel_a_s1_r, sel_a_s2_r;
  logic sel_b_s1_r, sel_b_s2_r;
  logic oe_n_s1_r, oe_n_s2_r;
  logic inhibit_r, inhibit_nxt;
  logic stage_vld_r;
  logic stage_vld_nxt;
  logic stage_up_r;
  logic stage_up_nxt;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic [CNT_W-1:0] latch_r;
  logic [CNT_W-1:0] latch_nxt;
  logic wrap_now;
  logic wrap_soon;
  logic clr_req;
  logic [BYTE_W-1:0] data_r;
  logic [BYTE_W-1:0] data_nxt;
  logic data_oe_r;
  logic data_oe_nxt;
  qcr_sel_e sel_code;
  qcr_bus_e bus_state_r;
  qcr_bus_e bus_state_nxt;
  logic [AV_DATA_W-1:0] rdata_r;
  logic [AV_DATA_W-1:0] rdata_nxt;
  logic [AV_DATA_W-1:0] ctrl_r;
  logic [AV_DATA_W-1:0] ctrl_nxt;
  logic ovf_r;
  logic ovf_nxt;
  logic unf_r;
  logic unf_nxt;
  logic bus_req;
  logic do_write;
  logic wr_low_lane;

  // Pin synchronisers on the falling edge, where the inhibit logic samples them.
  always_ff @(negedge clk_sys or posedge rst) begin
    if (rst) begin
      sel_a_s1_r <= 1'b1;
      sel_a_s2_r <= 1'b1;
      sel_b_s1_r <= 1'b1;
      sel_b_s2_r <= 1'b1;
      oe_n_s1_r <= 1'b1;
      oe_n_s2_r <= 1'b1;
    end else begin
      sel_a_s1_r <= byte_select_a;
      sel_a_s2_r <= sel_a_s1_r;
      sel_b_s1_r <= byte_select_b;
      sel_b_s2_r <= sel_b_s1_r;
      oe_n_s1_r <= out_enable_n;
      oe_n_s2_r <= oe_n_s1_r;
    end
  end

  assign sel_code = qcr_sel_e'({sel_a_s2_r, sel_b_s2_r});

  // Inhibit: set by a top-byte select with enable low, cleared by enable high.
  always_comb begin
    inhibit_nxt = inhibit_r;
    if (oe_n_s2_r) begin
      inhibit_nxt = 1'b0;
    end else if (sel_code == QCR_SEL_MSB) begin
      inhibit_nxt = 1'b1;
    end
  end

  // The inhibit changes only on falling edges; reset clears it at once.
  always_ff @(negedge clk_sys or posedge rst) begin
    if (rst) begin
      inhibit_r <= 1'b0;
    end else begin
      inhibit_r <= inhibit_nxt;
    end
  end

  // Decoder counts are staged one cycle so the cascade direction can lead the pulse.
  always_comb begin
    stage_vld_nxt = dec_count_strobe && ctrl_r[CTRL_EN_BIT];
    stage_up_nxt = dec_count_up;
    wrap_now = stage_vld_r && !clr_req && qcr_wraps(cnt_r, stage_up_r);
    cnt_nxt = cnt_r;
    if (clr_req) begin
      cnt_nxt = CNT_ZERO;
    end else if (stage_vld_r) begin
      cnt_nxt = qcr_step(cnt_r, stage_up_r);
    end
    wrap_soon = stage_vld_nxt && qcr_wraps(cnt_nxt, stage_up_nxt);
  end

  // The latch follows the counter except while the inhibit holds it.
  always_comb begin
    latch_nxt = latch_r;
    if (!inhibit_r) begin
      latch_nxt = cnt_r;
    end
  end

  // Counter, staging and position latch registers.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      stage_vld_r <= 1'b0;
      stage_up_r <= 1'b1;
      cnt_r <= CNT_ZERO;
      latch_r <= CNT_ZERO;
    end else begin
      stage_vld_r <= stage_vld_nxt;
      stage_up_r <= stage_up_nxt;
      cnt_r <= cnt_nxt;
      latch_r <= latch_nxt;
    end
  end

  // Byte multiplexer and bus enable, registered so the pins see clean edges.
  always_comb begin
    data_oe_nxt = !oe_n_s2_r;
    unique case (sel_code)
      QCR_SEL_MSB: data_nxt = latch_r[POS_MSB_LO +: BYTE_W];
      QCR_SEL_2ND: data_nxt = latch_r[POS_2ND_LO +: BYTE_W];
      QCR_SEL_3RD: data_nxt = latch_r[POS_3RD_LO +: BYTE_W];
      QCR_SEL_LSB: data_nxt = latch_r[POS_LSB_LO +: BYTE_W];
    endcase
  end

  // Registers for the data bus value and its drive enable.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      data_r <= '0;
      data_oe_r <= 1'b0;
    end else begin
      data_r <= data_nxt;
      data_oe_r <= data_oe_nxt;
    end
  end

  assign data_out = data_r;
  assign data_oe = data_oe_r;

  // Cascade outputs are fed from the counter, the decoder counts and the clear request, never from the inhibit.
  qcr_cascade u_cascade (
    .clk_sys(clk_sys),
    .rst(rst),
    .wrap_soon(wrap_soon),
    .wrap_soon_up(stage_up_nxt),
    .wrap_now(wrap_now),
    .cascade_count_pulse(cascade_count_pulse),
    .cascade_dir_up(cascade_dir_up)
  );

  // Avalon slave: one wait cycle, then the access completes.
  assign bus_req = avs_read || avs_write;
  assign avs_waitrequest = bus_req && (bus_state_r == QCR_BUS_IDLE);
  assign do_write = avs_write && (bus_state_r == QCR_BUS_ACK);
  assign wr_low_lane = do_write && avs_byteenable[BE_LOW_LANE];
  assign clr_req = wr_low_lane && (avs_address == OFS_CTRL) && avs_writedata[CTRL_CLR_BIT];
  assign avs_readdata = rdata_r;

  // Bus state, read data capture and register updates; hardware set wins over clear.
  always_comb begin
    bus_state_nxt = bus_state_r;
    rdata_nxt = rdata_r;
    ctrl_nxt = ctrl_r;
    ovf_nxt = ovf_r;
    unf_nxt = unf_r;
    unique case (bus_state_r)
      QCR_BUS_IDLE: begin
        if (bus_req) begin
          bus_state_nxt = QCR_BUS_ACK;
        end
        if (avs_read) begin
          unique case (avs_address)
            OFS_CTRL: rdata_nxt = ctrl_r;
            OFS_STATUS: begin
              rdata_nxt = '0;
              rdata_nxt[STAT_INH_BIT] = inhibit_r;
              rdata_nxt[STAT_OVF_BIT] = ovf_r;
              rdata_nxt[STAT_UNF_BIT] = unf_r;
              rdata_nxt[STAT_DOE_BIT] = data_oe_r;
            end
            OFS_COUNT: rdata_nxt = cnt_r;
            OFS_LATCH: rdata_nxt = latch_r;
            default: rdata_nxt = '0;
          endcase
        end
      end
      QCR_BUS_ACK: begin
        bus_state_nxt = QCR_BUS_IDLE;
      end
    endcase
    if (wr_low_lane && (avs_address == OFS_CTRL)) begin
      ctrl_nxt = '0;
      ctrl_nxt[CTRL_EN_BIT] = avs_writedata[CTRL_EN_BIT];
    end
    if (wr_low_lane && (avs_address == OFS_STATUS)) begin
      if (avs_writedata[STAT_OVF_BIT]) begin
        ovf_nxt = 1'b0;
      end
      if (avs_writedata[STAT_UNF_BIT]) begin
        unf_nxt = 1'b0;
      end
    end
    if (wrap_now && stage_up_r) begin
      ovf_nxt = 1'b1;
    end
    if (wrap_now && !stage_up_r) begin
      unf_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      bus_state_r <= QCR_BUS_IDLE;
      rdata_r <= '0;
      ctrl_r <= CTRL_RST;
      ovf_r <= 1'b0;
      unf_r <= 1'b0;
    end else begin
      bus_state_r <= bus_state_nxt;
      rdata_r <= rdata_nxt;
      ctrl_r <= ctrl_nxt;
      ovf_r <= ovf_nxt;
      unf_r <= unf_nxt;
    end
  end

  // Checks on the read path and counter.
  property p_latch_hold;
    @(posedge clk_sys) disable iff (rst)
    inhibit_r |=> latch_r == $past(latch_r);
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latch moved while inhibited");

  property p_latch_track;
    @(posedge clk_sys) disable iff (rst)
    !inhibit_r |=> latch_r == $past(cnt_r);
  endproperty
  a_latch_track: assert property (p_latch_track) else $error("latch missed the counter value");

  property p_inhibit_set;
    @(negedge clk_sys) disable iff (rst)
    !oe_n_s2_r && sel_code == QCR_SEL_MSB |=> inhibit_r;
  endproperty
  a_inhibit_set: assert property (p_inhibit_set) else $error("inhibit not set by top-byte select");

  sequence s_read_steps;
    inhibit_r && !oe_n_s2_r && sel_code != QCR_SEL_MSB;
  endsequence

  property p_inhibit_stays;
    @(negedge clk_sys) disable iff (rst)
    s_read_steps |=> inhibit_r;
  endproperty
  a_inhibit_stays: assert property (p_inhibit_stays) else $error("inhibit dropped during read");

  property p_inhibit_clear;
    @(negedge clk_sys) disable iff (rst)
    oe_n_s2_r |=> !inhibit_r;
  endproperty
  a_inhibit_clear: assert property (p_inhibit_clear) else $error("inhibit not cleared by enable high");

  property p_bus_float;
    @(posedge clk_sys) disable iff (rst)
    oe_n_s2_r ##1 oe_n_s2_r |-> !data_oe;
  endproperty
  a_bus_float: assert property (p_bus_float) else $error("data bus driven with enable high");

  property p_msb_out;
    @(posedge clk_sys) disable iff (rst)
    inhibit_r && sel_code == QCR_SEL_MSB |=> data_out == latch_r[POS_MSB_LO +: BYTE_W];
  endproperty
  a_msb_out: assert property (p_msb_out) else $error("top byte not on the bus");

  sequence s_wrap_up;
    stage_vld_r && stage_up_r && !clr_req && cnt_r == CNT_ONES;
  endsequence

  property p_overflow;
    @(negedge clk_sys) disable iff (rst)
    s_wrap_up |=> cnt_r == CNT_ZERO && cascade_count_pulse;
  endproperty
  a_overflow: assert property (p_overflow) else $error("overflow gave no zero or no pulse");

  property p_pulse_during_read;
    @(negedge clk_sys) disable iff (rst)
    wrap_now && inhibit_r |=> cascade_count_pulse;
  endproperty
  a_pulse_during_read: assert property (p_pulse_during_read) else $error("cascade pulse lost while inhibited");

endmodule

// [inc/qcr_pkg.sv]
package qcr_pkg;

  // Widths of the position path and of the register bus.
  localparam int CNT_W = 32;
  localparam int BYTE_W = 8;
  localparam int AV_ADDR_W = 4;
  localparam int AV_DATA_W = 32;
  localparam int AV_BE_W = 4;

  // Register byte offsets on the Avalon-MM slave.
  localparam logic [AV_ADDR_W-1:0] OFS_CTRL = 4'h0;
  localparam logic [AV_ADDR_W-1:0] OFS_STATUS = 4'h4;
  localparam logic [AV_ADDR_W-1:0] OFS_COUNT = 4'h8;
  localparam logic [AV_ADDR_W-1:0] OFS_LATCH = 4'hC;

  // Control register fields and reset value.
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_CLR_BIT = 1;
  localparam logic [AV_DATA_W-1:0] CTRL_RST = 32'h0000_0001;

  // Status register fields.
  localparam int STAT_INH_BIT = 0;
  localparam int STAT_OVF_BIT = 1;
  localparam int STAT_UNF_BIT = 2;
  localparam int STAT_DOE_BIT = 3;

  // Byte-enable lane that carries the low control and status bits.
  localparam int BE_LOW_LANE = 0;

  // Counter boundary values.
  localparam logic [CNT_W-1:0] CNT_ONES = 32'hFFFF_FFFF;
  localparam logic [CNT_W-1:0] CNT_ZERO = 32'h0000_0000;
  localparam logic [CNT_W-1:0] CNT_ONE = 32'h0000_0001;

  // Low bit position of each byte of the position latch.
  localparam int POS_MSB_LO = 24;
  localparam int POS_2ND_LO = 16;
  localparam int POS_3RD_LO = 8;
  localparam int POS_LSB_LO = 0;

  // Byte select code, written as {byte_select_a, byte_select_b}.
  typedef enum logic [1:0] {
    QCR_SEL_3RD = 2'b00,
    QCR_SEL_MSB = 2'b01,
    QCR_SEL_LSB = 2'b10,
    QCR_SEL_2ND = 2'b11
  } qcr_sel_e;

  // Register bus handshake states.
  typedef enum logic {
    QCR_BUS_IDLE = 1'b0,
    QCR_BUS_ACK = 1'b1
  } qcr_bus_e;

endpackage

// [core/qcr_cascade.sv]
`timescale 1ns/1ns
module qcr_cascade (
  input wire logic clk_sys, // System clock.
  input wire logic rst, // Asynchronous reset, active high.
  input wire logic wrap_soon, // Counter will wrap at the edge after the next one.
  input wire logic wrap_soon_up, // Direction of that coming wrap, 1 = up.
  input wire logic wrap_now, // Counter wraps at this edge.
  output logic cascade_count_pulse, // Half-cycle pulse per wrap.
  output logic cascade_dir_up // Cascade direction, 1 = up.
);
  import qcr_pkg::*;

  logic pos_tog_r;
  logic pos_tog_nxt;
  logic neg_tog_r;
  logic dir_r;
  logic dir_nxt;

  // A wrap flips the rising-edge toggle; the falling-edge copy catches up half a cycle later.
  always_comb begin
    pos_tog_nxt = pos_tog_r ^ wrap_now;
    dir_nxt = dir_r;
    if (wrap_soon && !wrap_now) begin
      dir_nxt = wrap_soon_up;
    end
  end

  // Rising-edge state of the cascade outputs.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pos_tog_r <= 1'b0;
      dir_r <= 1'b1;
    end else begin
      pos_tog_r <= pos_tog_nxt;
      dir_r <= dir_nxt;
    end
  end

  // Falling-edge follower that ends each pulse at mid-cycle.
  always_ff @(negedge clk_sys or posedge rst) begin
    if (rst) begin
      neg_tog_r <= 1'b0;
    end else begin
      neg_tog_r <= pos_tog_r;
    end
  end

  // The pulse is high from the wrapping rising edge to the following falling edge.
  assign cascade_count_pulse = pos_tog_r ^ neg_tog_r;
  assign cascade_dir_up = dir_r;

  // Direction is held one cycle after a pulse and settled one cycle ahead of it, except for a wrap one cycle after a wrap, which keeps the old direction.
  sequence s_wrap_ahead;
    wrap_soon && !wrap_now ##1 wrap_now;
  endsequence

  property p_dir_settled;
    @(posedge clk_sys) disable iff (rst)
    s_wrap_ahead |-> cascade_dir_up == $past(wrap_soon_up);
  endproperty
  a_dir_settled: assert property (p_dir_settled) else $error("cascade direction not set before pulse");

  property p_dir_held;
    @(posedge clk_sys) disable iff (rst)
    wrap_now |=> $stable(cascade_dir_up);
  endproperty
  a_dir_held: assert property (p_dir_held) else $error("cascade direction moved right after pulse");

  property p_pulse_rises;
    @(posedge clk_sys) disable iff (rst)
    wrap_now |=> $changed(pos_tog_r) ##1 (!$changed(pos_tog_r) || $past(wrap_now));
  endproperty
  a_pulse_rises: assert property (p_pulse_rises) else $error("no cascade pulse after wrap");

  property p_pulse_half;
    @(posedge clk_sys) disable iff (rst)
    1'b1 |-> !cascade_count_pulse;
  endproperty
  a_pulse_half: assert property (p_pulse_half) else $error("cascade pulse longer than half a cycle");

endmodule

// [bench/qcr_far_side.sv]
`timescale 1ns/1ns
// Host side of the pins plus an outside extension counter with its own latch.
module qcr_far_side (
  input wire logic clk_sys, // System clock.
  input wire logic rst, // Reset, active high.
  input wire logic cascade_count_pulse, // Cascade count from the block.
  input wire logic cascade_dir_up, // Cascade direction, 1 = up.
  input wire logic out_enable_n, // Host output enable pin.
  input wire logic byte_select_a, // Host byte select a.
  input wire logic [7:0] data_out, // Block data value.
  input wire logic data_oe, // Block drive enable.
  output logic [7:0] data_bus, // Resolved data bus.
  output logic [7:0] ext_cnt_r, // Extension counter.
  output logic [7:0] ext_lat_r // Extension latch.
);
  logic [7:0] last_r;
  // The host sets 4X decoding and the X axis before any read.
  logic count_mode_pin_a = 1'b1;
  logic count_mode_pin_b = 1'b0;
  logic axis_select = 1'b0;
  logic armed_r = 1'b0;

  // A floating bus shows the inverse of the last driven value, never a stale copy.
  assign data_bus = data_oe ? data_out : ~last_r;
  always @(posedge clk_sys or posedge rst) begin
    if (rst)
      last_r <= 8'h00;
    else if (data_oe)
      last_r <= data_out;
  end

  // The extension counter takes every cascade pulse, also one in the cycle a read starts.
  always @(posedge cascade_count_pulse or posedge rst) begin
    if (rst)
      ext_cnt_r <= 8'h00;
    else if (cascade_dir_up)
      ext_cnt_r <= ext_cnt_r + 8'h01;
    else
      ext_cnt_r <= ext_cnt_r - 8'h01;
  end

  // The latch is taken once as the top-byte read starts, before a pulse can ripple through.
  // It reacts to pin levels, so the order in which both pins change does not matter.
  always @(out_enable_n or byte_select_a or rst) begin
    if (rst) begin
      ext_lat_r <= 8'h00;
      armed_r = 1'b0;
    end else if (out_enable_n) begin
      armed_r = 1'b0;
    end else if (!byte_select_a && !armed_r && count_mode_pin_a && !count_mode_pin_b && !axis_select) begin
      ext_lat_r <= ext_cnt_r;
      armed_r = 1'b1;
    end
  end
endmodule

// [bench/quad_counter_cascade_readout_tb.sv]
`timescale 1ns/1ns
module quad_counter_cascade_readout_tb;
  import qcr_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b0;
  logic [AV_ADDR_W-1:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [AV_DATA_W-1:0] avs_writedata = 32'h0000_0000;
  logic [AV_BE_W-1:0] avs_byteenable = 4'hF;
  logic [AV_DATA_W-1:0] avs_readdata;
  logic avs_waitrequest;
  logic dec_count_strobe = 1'b0;
  logic dec_count_up = 1'b1;
  logic byte_select_a = 1'b1;
  logic byte_select_b = 1'b1;
  logic out_enable_n = 1'b1;
  logic [BYTE_W-1:0] data_out;
  logic data_oe;
  logic cascade_count_pulse;
  logic cascade_dir_up;
  logic [7:0] data_bus;
  logic [7:0] ext_cnt_r;
  logic [7:0] ext_lat_r;
  logic [31:0] rd;
  int n_fail = 0;
  int checks = 0;

  // System clock, 10 ns period.
  always #5 clk_sys = ~clk_sys;

  qcr_readout dut (.clk_sys(clk_sys), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .dec_count_strobe(dec_count_strobe),
    .dec_count_up(dec_count_up), .byte_select_a(byte_select_a), .byte_select_b(byte_select_b),
    .out_enable_n(out_enable_n), .data_out(data_out), .data_oe(data_oe),
    .cascade_count_pulse(cascade_count_pulse), .cascade_dir_up(cascade_dir_up));

  qcr_far_side far (.clk_sys(clk_sys), .rst(rst), .cascade_count_pulse(cascade_count_pulse),
    .cascade_dir_up(cascade_dir_up), .out_enable_n(out_enable_n), .byte_select_a(byte_select_a),
    .data_out(data_out), .data_oe(data_oe), .data_bus(data_bus), .ext_cnt_r(ext_cnt_r),
    .ext_lat_r(ext_lat_r));

  // Prints the verdict and ends the run.
  task automatic complete_run();
    if (n_fail == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Compares one value against its expectation.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  // A used-up wait counts as a mismatch and closes the run.
  task automatic hang(input string msg);
    n_fail++;
    $display("wrong value at %0t: %s timed out", $time, msg);
    complete_run();
  endtask

  // One Avalon transfer, held until waitrequest is seen low, then released.
  task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] wd, output logic [31:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= wd;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    if (avs_waitrequest !== 1'b0)
      hang("bus");
    d = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk_sys);
  endtask

  // Reads one register and compares it.
  task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp, input string msg);
    av(1'b0, a, 32'h0000_0000, rd);
    chk(rd, exp, msg);
  endtask

  // Sends decoder counts, one every other cycle.
  task automatic strobe(input logic up, input int n);
    repeat (n) begin
      dec_count_strobe <= 1'b1;
      dec_count_up <= up;
      @(posedge clk_sys);
      dec_count_strobe <= 1'b0;
      @(posedge clk_sys);
    end
  endtask

  // Moves the host pins and lets them pass the falling-edge synchronisers.
  task automatic pins(input logic oe_n, input logic a, input logic b);
    out_enable_n <= oe_n;
    byte_select_a <= a;
    byte_select_b <= b;
    repeat (5) @(posedge clk_sys);
  endtask

  // One count that wraps the counter, watching both cascade outputs around it.
  task automatic wrap(input logic up);
    dec_count_strobe <= 1'b1;
    dec_count_up <= up;
    @(posedge clk_sys);
    dec_count_strobe <= 1'b0;
    #1;
    chk(cascade_dir_up, up, "dir before pulse");
    chk(cascade_count_pulse, 1'b0, "pulse early");
    @(posedge clk_sys);
    #1;
    chk(cascade_count_pulse, 1'b1, "pulse at wrap");
    @(negedge clk_sys);
    #1;
    chk(cascade_count_pulse, 1'b0, "pulse half cycle");
    @(posedge clk_sys);
    #1;
    chk(cascade_dir_up, up, "dir after pulse");
    @(posedge clk_sys);
  endtask

  // Reset values, count enable and an unmapped read.
  task automatic s_reset();
    chk(data_oe, 1'b0, "bus floats");
    rd_chk(OFS_CTRL, CTRL_RST, "ctrl reset");
    rd_chk(OFS_LATCH, CNT_ZERO, "latch reset");
    rd_chk(4'h2, 32'h0000_0000, "unmapped");
    av(1'b1, OFS_CTRL, 32'h0000_0000, rd);
    strobe(1'b1, 1);
    rd_chk(OFS_COUNT, CNT_ZERO, "disabled count");
    av(1'b1, OFS_CTRL, CTRL_RST, rd);
  endtask

  // Underflow then overflow while a read holds the latch; the cascade keeps going.
  task automatic s_wrap();
    pins(1'b0, 1'b0, 1'b1);
    wrap(1'b0);
    rd_chk(OFS_COUNT, CNT_ONES, "underflow");
    rd_chk(OFS_LATCH, CNT_ZERO, "latch held");
    rd_chk(OFS_STATUS, 32'h0000_000D, "underflow flag");
    chk(ext_cnt_r, 8'hFF, "ext after down");
    wrap(1'b1);
    rd_chk(OFS_COUNT, CNT_ZERO, "overflow");
    chk(ext_cnt_r, 8'h00, "ext after up");
    rd_chk(OFS_STATUS, 32'h0000_000F, "both wrap flags");
    av(1'b1, OFS_STATUS, 32'h0000_0006, rd);
    rd_chk(OFS_STATUS, 32'h0000_0009, "flags cleared");
    pins(1'b1, 1'b1, 1'b1);
  endtask

  // Reset in the middle of a read drops the inhibit and the bus at once.
  task automatic s_mid_reset();
    pins(1'b0, 1'b0, 1'b1);
    rst <= 1'b1;
    #1;
    chk(data_oe, 1'b0, "bus off in reset");
    @(posedge clk_sys);
    out_enable_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (4) @(posedge clk_sys);
    av(1'b0, OFS_STATUS, 32'h0000_0000, rd);
    chk(rd[STAT_INH_BIT], 1'b0, "inhibit after reset");
  endtask

  // Four-byte read while counts keep arriving, then release and reload.
  task automatic s_read();
    strobe(1'b1, 258);
    pins(1'b0, 1'b0, 1'b1);
    chk(data_oe, 1'b1, "bus driven");
    chk(data_bus, 8'h00, "top byte");
    chk(ext_lat_r, ext_cnt_r, "ext latch");
    av(1'b0, OFS_STATUS, 32'h0000_0000, rd);
    chk(rd[STAT_INH_BIT], 1'b1, "inhibit set");
    strobe(1'b1, 3);
    pins(1'b0, 1'b1, 1'b1);
    chk(data_bus, 8'h00, "second byte");
    pins(1'b0, 1'b0, 1'b0);
    chk(data_bus, 8'h01, "third byte");
    pins(1'b0, 1'b1, 1'b0);
    chk(data_bus, 8'h02, "low byte");
    rd_chk(OFS_LATCH, 32'h0000_0102, "latch frozen");
    rd_chk(OFS_COUNT, 32'h0000_0105, "count moves");
    pins(1'b1, 1'b0, 1'b1);
    chk(data_oe, 1'b0, "bus released");
    av(1'b0, OFS_STATUS, 32'h0000_0000, rd);
    chk(rd[STAT_INH_BIT], 1'b0, "inhibit clear");
    rd_chk(OFS_LATCH, 32'h0000_0105, "latch reload");
    av(1'b1, OFS_CTRL, 32'h0000_0003, rd);
    rd_chk(OFS_COUNT, CNT_ZERO, "counter clear");
    rd_chk(OFS_CTRL, CTRL_RST, "clear bit self clears");
  endtask

  // Main sequence after four cycles of reset.
  initial begin
    rst <= 1'b1;
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    s_reset();
    s_wrap();
    s_mid_reset();
    s_read();
    complete_run();
  end

  // Cuts a hang short.
  initial begin
    #200000;
    hang("run");
  end
endmodule
